/* hw/imupm_ctrl.v */
// Purpose: Mode and data-rate control of a combined accelerometer and gyroscope.
// Assumes: Host is a two-wire serial master; SCL and SDA are sampled by mclk_i.
// Notes:   SDA is open drain: the pad pulls low while sda_oe_o is high.
`include "imupm_regs.vh"

module imupm_ctrl #(
    parameter [6:0] DEV_ADDR      = 7'h35,  // Arbitrary bus address.
    parameter       GYRO_NEGATE   = 0,      // Set when the front end counts clockwise positive.
    parameter       ACC_OFFSETBIN = 0       // Set when the front end delivers offset binary.
) (
    input  wire        mclk_i,
    input  wire        resetn_i,
    input  wire        ce_i,
    input  wire        scl_i,
    input  wire        sda_i,
    output reg         sda_o,
    output reg         sda_oe_o,
    input  wire        sample_valid_i,
    input  wire [47:0] accel_sample_i,
    input  wire [47:0] gyro_sample_i,
    output reg         accel_on_o,
    output reg         gyro_on_o,
    output reg  [2:0]  odr_o,
    output reg  [1:0]  gyro_pmode_o,
    output reg  [1:0]  gyro_fs_o,
    output reg  [1:0]  accel_bw_o,
    output reg  [4:0]  discard_left_o
);

    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_ADDR = 3'h1;
    localparam [2:0] S_ACKA = 3'h2;
    localparam [2:0] S_WR   = 3'h3;
    localparam [2:0] S_ACKW = 3'h4;
    localparam [2:0] S_RD   = 3'h5;
    localparam [2:0] S_ACKR = 3'h6;

    reg        scl_m, scl_q, scl_d;
    reg        sda_m, sda_q, sda_d;
    reg [2:0]  st;
    reg [3:0]  cnt;
    reg [7:0]  shreg, ptr, wr_adr, wr_dat, rd_adr;
    reg        rnw, nack, ptr_phase, wr_stb, rd_stb;
    reg [7:0]  gyro_ctrl, gyro_pwr, acc_ctrl, rd_data;
    reg        combined, gyro_rdy, accel_rdy;
    reg [47:0] gyro_data, accel_data;
    wire [7:0] gyro_idx, acc_idx;
    wire       scl_rise, scl_fall, i2c_start, i2c_stop;
    wire [2:0] eff_rate;
    wire       gyro_run, gyro_switch, acc_wake;
    wire [1:0] pmode;
    wire [4:0] gdisc, adisc;

    // Picks byte i of a three-axis sample, low byte of X first.
    function [7:0] sel_byte;
        input [47:0] w;
        input [2:0]  i;
        begin
            sel_byte = w[{i, 3'h0} +: 8];
        end
    endfunction

    // Brings a raw sample into the output convention, axis by axis.
    function [47:0] fix_axes;
        input [47:0] v;
        input        negate;
        input        flip_msb;
        integer      k;
        reg   [15:0] a;
        begin
            fix_axes = 48'h0;
            for (k = 0; k < 3; k = k + 1) begin
                a = v[k*16 +: 16];
                if (negate) a = 16'h0000 - a;
                if (flip_msb) a = a ^ 16'h8000;
                fix_axes[k*16 +: 16] = a;
            end
        end
    endfunction

    // Two-stage synchronisers on the serial pins, then a delayed copy for edges.
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_m <= 1'b1;
            scl_q <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_q <= 1'b1;
            sda_d <= 1'b1;
        end else if (ce_i) begin
            scl_m <= scl_i;
            scl_q <= scl_m;
            scl_d <= scl_q;
            sda_m <= sda_i;
            sda_q <= sda_m;
            sda_d <= sda_q;
        end
    end

    // Bus events seen on the synchronised pins.
    assign scl_rise  = scl_q & ~scl_d;
    assign scl_fall  = ~scl_q & scl_d;
    assign i2c_start = scl_q & scl_d & sda_d & ~sda_q;
    assign i2c_stop  = scl_q & scl_d & ~sda_d & sda_q;

    // Serial slave: address, register pointer, then data with pointer increment.
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st        <= S_IDLE;
            cnt       <= 4'h0;
            shreg     <= 8'h00;
            ptr       <= 8'h00;
            rnw       <= 1'b0;
            nack      <= 1'b0;
            ptr_phase <= 1'b0;
            wr_stb    <= 1'b0;
            wr_adr    <= 8'h00;
            wr_dat    <= 8'h00;
            rd_stb    <= 1'b0;
            rd_adr    <= 8'h00;
            sda_o     <= 1'b0;
            sda_oe_o  <= 1'b0;
        end else if (ce_i) begin
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            if (i2c_start) begin
                st       <= S_ADDR;
                cnt      <= 4'h0;
                sda_oe_o <= 1'b0;
            end else if (i2c_stop) begin
                st       <= S_IDLE;
                sda_oe_o <= 1'b0;
            end else if (scl_rise) begin
                case (st)
                    S_ADDR, S_WR: begin
                        shreg <= {shreg[6:0], sda_q};
                        cnt   <= cnt + 4'h1;
                    end
                    S_RD:    cnt  <= cnt + 4'h1;
                    S_ACKR:  nack <= sda_q;
                    default: cnt  <= cnt;
                endcase
            end else if (scl_fall) begin
                case (st)
                    S_ADDR: begin
                        if (cnt == `IMUPM_BITS_PER_BYTE) begin
                            if (shreg[7:1] == DEV_ADDR) begin
                                st       <= S_ACKA;
                                rnw      <= shreg[0];
                                sda_oe_o <= 1'b1;
                            end else begin
                                st <= S_IDLE;
                            end
                        end
                    end
                    S_ACKA, S_ACKR: begin
                        if ((st == S_ACKA && rnw) || (st == S_ACKR && !nack)) begin
                            shreg    <= {rd_data[6:0], 1'b0};
                            sda_oe_o <= ~rd_data[7];
                            rd_stb   <= 1'b1;
                            rd_adr   <= ptr;
                            ptr      <= ptr + 8'h01;
                            cnt      <= 4'h0;
                            st       <= S_RD;
                        end else if (st == S_ACKA) begin
                            sda_oe_o  <= 1'b0;
                            st        <= S_WR;
                            cnt       <= 4'h0;
                            ptr_phase <= 1'b1;
                        end else begin
                            st <= S_IDLE;
                        end
                    end
                    S_WR: begin
                        if (cnt == `IMUPM_BITS_PER_BYTE) begin
                            st       <= S_ACKW;
                            sda_oe_o <= 1'b1;
                            if (ptr_phase) begin
                                ptr <= shreg;
                            end else begin
                                wr_stb <= 1'b1;
                                wr_adr <= ptr;
                                wr_dat <= shreg;
                                ptr    <= ptr + 8'h01;
                            end
                        end
                    end
                    S_ACKW: begin
                        sda_oe_o  <= 1'b0;
                        st        <= S_WR;
                        cnt       <= 4'h0;
                        ptr_phase <= 1'b0;
                    end
                    S_RD: begin
                        if (cnt == `IMUPM_BITS_PER_BYTE) begin
                            sda_oe_o <= 1'b0;
                            st       <= S_ACKR;
                        end else begin
                            sda_oe_o <= ~shreg[7];
                            shreg    <= {shreg[6:0], 1'b0};
                        end
                    end
                    default: st <= S_IDLE;
                endcase
            end
        end
    end

    // Read multiplexer over control, status and output registers.
    assign gyro_idx = ptr - `IMUPM_ADR_GYRO_OUT;
    assign acc_idx  = ptr - `IMUPM_ADR_ACC_OUT;
    always @* begin
        if (ptr == `IMUPM_ADR_GYRO_CTRL) begin
            rd_data = gyro_ctrl;
        end else if (ptr == `IMUPM_ADR_GYRO_PWR) begin
            rd_data = gyro_pwr;
        end else if (ptr == `IMUPM_ADR_ACC_CTRL) begin
            rd_data = acc_ctrl;
        end else if (ptr == `IMUPM_ADR_STATUS) begin
            rd_data = {3'h0, combined, gyro_pmode_o, gyro_rdy, accel_rdy};
        end else if (gyro_idx <= `IMUPM_OUT_LAST_IDX) begin
            rd_data = sel_byte(gyro_data, gyro_idx[2:0]);
        end else if (acc_idx <= `IMUPM_OUT_LAST_IDX) begin
            rd_data = sel_byte(accel_data, acc_idx[2:0]);
        end else begin
            rd_data = 8'h00;
        end
    end

    // Control registers; of the gyroscope and accelerometer control registers, the one written last decides the operating mode.
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gyro_ctrl <= `IMUPM_RST_CTRL;
            gyro_pwr  <= `IMUPM_RST_CTRL;
            acc_ctrl  <= `IMUPM_RST_CTRL;
            combined  <= 1'b0;
        end else if (ce_i && wr_stb) begin
            if (wr_adr == `IMUPM_ADR_GYRO_CTRL) begin
                gyro_ctrl <= wr_dat;
                combined  <= 1'b1;
            end else if (wr_adr == `IMUPM_ADR_GYRO_PWR) begin
                gyro_pwr <= wr_dat;
            end else if (wr_adr == `IMUPM_ADR_ACC_CTRL) begin
                acc_ctrl <= wr_dat;
                combined <= 1'b0;
            end
        end
    end

    // Shared rate in combined mode, own rate when the accelerometer runs alone.
    assign eff_rate = combined ? gyro_ctrl[`IMUPM_RATE_HI:`IMUPM_RATE_LO]
                               : acc_ctrl[`IMUPM_RATE_HI:`IMUPM_RATE_LO];
    assign gyro_run = combined;

    imupm_mode_dec u_dec (
        .rate_i     (gyro_ctrl[`IMUPM_RATE_HI:`IMUPM_RATE_LO]),
        .lp_en_i    (gyro_pwr[`IMUPM_LP_BIT]),
        .fs_i       (gyro_ctrl[`IMUPM_FS_HI:`IMUPM_FS_LO]),
        .gyro_on_i  (gyro_run),
        .second_lowpass_filter_i     (gyro_pwr[`IMUPM_SECOND_LOWPASS_FILTER_BIT]),
        .acc_rate_i (eff_rate),
        .bw_i       (acc_ctrl[`IMUPM_BW_HI:`IMUPM_BW_LO]),
        .pmode_o    (pmode),
        .gdisc_o    (gdisc),
        .adisc_o    (adisc)
    );

    // Settling is counted on a low-power/normal switch or an accelerometer wake-up.
    assign gyro_switch = (pmode == `IMUPM_PM_LOW && gyro_pmode_o == `IMUPM_PM_NORMAL) ||
                         (pmode == `IMUPM_PM_NORMAL && gyro_pmode_o == `IMUPM_PM_LOW);
    assign acc_wake    = (odr_o == `IMUPM_RATE_OFF) && (eff_rate != `IMUPM_RATE_OFF);

    // Front-end controls and the settling counter.
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            accel_on_o     <= 1'b0;
            gyro_on_o      <= 1'b0;
            odr_o          <= `IMUPM_RATE_OFF;
            gyro_pmode_o   <= `IMUPM_PM_DOWN;
            gyro_fs_o      <= 2'h0;
            accel_bw_o     <= 2'h0;
            discard_left_o <= 5'h00;
        end else if (ce_i) begin
            accel_on_o   <= eff_rate != `IMUPM_RATE_OFF;
            gyro_on_o    <= pmode != `IMUPM_PM_DOWN;
            odr_o        <= eff_rate;
            gyro_pmode_o <= pmode;
            gyro_fs_o    <= gyro_ctrl[`IMUPM_FS_HI:`IMUPM_FS_LO];
            accel_bw_o   <= acc_ctrl[`IMUPM_BW_HI:`IMUPM_BW_LO];
            if (gyro_switch || acc_wake) begin
                discard_left_o <= (gyro_switch && (!acc_wake || gdisc > adisc)) ? gdisc : adisc;
            end else if (sample_valid_i && discard_left_o != 5'h00) begin
                discard_left_o <= discard_left_o - 5'h01;
            end
        end
    end

    // Sample capture; ready flags rise once settled and clear when X low is read.
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gyro_data  <= 48'h0;
            accel_data <= 48'h0;
            gyro_rdy   <= 1'b0;
            accel_rdy  <= 1'b0;
        end else if (ce_i) begin
            if (sample_valid_i && accel_on_o) begin
                accel_data <= fix_axes(accel_sample_i, 1'b0, ACC_OFFSETBIN != 0);
            end
            if (sample_valid_i && gyro_on_o) gyro_data <= fix_axes(gyro_sample_i, GYRO_NEGATE != 0, 1'b0);
            if (sample_valid_i && accel_on_o && discard_left_o == 5'h00) begin
                accel_rdy <= 1'b1;
            end else if (rd_stb && rd_adr == `IMUPM_ADR_ACC_OUT) begin
                accel_rdy <= 1'b0;
            end
            if (sample_valid_i && gyro_on_o && discard_left_o == 5'h00) begin
                gyro_rdy <= 1'b1;
            end else if (rd_stb && rd_adr == `IMUPM_ADR_GYRO_OUT) begin
                gyro_rdy <= 1'b0;
            end
        end
    end

endmodule // imupm_ctrl

/* hw/imupm_mode_dec.v */
// Purpose: Decodes the gyroscope power mode and the settling sample counts.
// Assumes: Purely combinational; the caller registers the results.
// Notes:   Counts are samples the host should drop after a mode change.
`include "imupm_regs.vh"

module imupm_mode_dec (
    input  wire [2:0] rate_i,
    input  wire       lp_en_i,
    input  wire [1:0] fs_i,
    input  wire       gyro_on_i,
    input  wire       second_lowpass_filter_i,
    input  wire [2:0] acc_rate_i,
    input  wire [1:0] bw_i,
    output reg  [1:0] pmode_o,
    output reg  [4:0] gdisc_o,
    output reg  [4:0] adisc_o
);

    // Power mode: low rates may run low power, high rates always run normal.
    always @* begin
        if (!gyro_on_i || rate_i == `IMUPM_RATE_OFF) begin
            pmode_o = `IMUPM_PM_DOWN;
        end else if (rate_i <= `IMUPM_RATE_119HZ && lp_en_i && fs_i == `IMUPM_FS_2000DPS) begin
            pmode_o = `IMUPM_PM_LOW;
        end else begin
            pmode_o = `IMUPM_PM_NORMAL;
        end
    end

    // Gyroscope settling samples; the second filter does not exist at the lowest rate.
    always @* begin
        case (rate_i)
            `IMUPM_RATE_14HZ:  gdisc_o = 5'h02;
            `IMUPM_RATE_59HZ:  gdisc_o = second_lowpass_filter_i ? 5'h0d : 5'h03;
            `IMUPM_RATE_119HZ: gdisc_o = second_lowpass_filter_i ? 5'h0d : 5'h03;
            `IMUPM_RATE_238HZ: gdisc_o = second_lowpass_filter_i ? 5'h0e : 5'h04;
            `IMUPM_RATE_476HZ: gdisc_o = second_lowpass_filter_i ? 5'h0f : 5'h05;
            `IMUPM_RATE_952HZ: gdisc_o = second_lowpass_filter_i ? 5'h12 : 5'h08;
            default:           gdisc_o = 5'h00;
        endcase
    end

    // Accelerometer settling samples by rate and bandwidth.
    always @* begin
        case (acc_rate_i)
            `IMUPM_RATE_119HZ: adisc_o = (bw_i == `IMUPM_BW_50) ? 5'h02 : 5'h01;
            `IMUPM_RATE_238HZ: adisc_o = (bw_i == `IMUPM_BW_50) ? 5'h04 : (bw_i == `IMUPM_BW_100) ? 5'h02 : 5'h01;
            `IMUPM_RATE_476HZ: adisc_o = (bw_i == `IMUPM_BW_50) ? 5'h07 : (bw_i == `IMUPM_BW_100) ? 5'h04 :
                                         (bw_i == `IMUPM_BW_200) ? 5'h02 : 5'h01;
            `IMUPM_RATE_952HZ: adisc_o = (bw_i == `IMUPM_BW_50) ? 5'h0e : (bw_i == `IMUPM_BW_100) ? 5'h07 :
                                         (bw_i == `IMUPM_BW_200) ? 5'h04 : 5'h02;
            default:           adisc_o = 5'h00;
        endcase
    end

endmodule // imupm_mode_dec

/* hw/imupm_regs.vh */
// Purpose: Register map, field positions and codes of the motion sensor mode control.
// Assumes: Byte-wide registers reached over the two-wire serial slave port.
// Notes:   Definitions only; included by both design files.
`ifndef IMUPM_REGS_VH
`define IMUPM_REGS_VH

// Register addresses.
`define IMUPM_ADR_GYRO_CTRL  8'h10
`define IMUPM_ADR_GYRO_PWR   8'h12
`define IMUPM_ADR_GYRO_OUT   8'h18
`define IMUPM_ADR_STATUS     8'h27
`define IMUPM_ADR_ACC_CTRL   8'h20
`define IMUPM_ADR_ACC_OUT    8'h28
`define IMUPM_OUT_LAST_IDX   8'h05

// Reset value of every control register.
`define IMUPM_RST_CTRL       8'h00

// Fields of the rate and control registers.
`define IMUPM_RATE_HI        7
`define IMUPM_RATE_LO        5
`define IMUPM_FS_HI          4
`define IMUPM_FS_LO          3
`define IMUPM_BW_HI          1
`define IMUPM_BW_LO          0
`define IMUPM_LP_BIT         7
`define IMUPM_SECOND_LOWPASS_FILTER_BIT       6

// Rate codes and full-scale code.
`define IMUPM_RATE_OFF       3'h0
`define IMUPM_RATE_14HZ      3'h1
`define IMUPM_RATE_59HZ      3'h2
`define IMUPM_RATE_119HZ     3'h3
`define IMUPM_RATE_238HZ     3'h4
`define IMUPM_RATE_476HZ     3'h5
`define IMUPM_RATE_952HZ     3'h6
`define IMUPM_FS_2000DPS     2'h3

// Gyroscope power modes.
`define IMUPM_PM_DOWN        2'h0
`define IMUPM_PM_LOW         2'h1
`define IMUPM_PM_NORMAL      2'h2

// Accelerometer bandwidth codes.
`define IMUPM_BW_400         2'h0
`define IMUPM_BW_200         2'h1
`define IMUPM_BW_100         2'h2
`define IMUPM_BW_50          2'h3

// Serial framing.
`define IMUPM_BITS_PER_BYTE  4'h8

`endif

/* test/imupm_ctrl_assertions.sv */
// Purpose: Concurrent checks on the mode and discard outputs of the sensor mode control.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   Discard checks wait until rate and power mode have been calm for three cycles.
module imupm_ctrl_assertions (
    input wire logic       mclk_i,
    input wire logic       resetn_i,
    input wire logic       ce_i,
    input wire logic       sample_valid_i,
    input wire logic       sda_o,
    input wire logic       accel_on_o,
    input wire logic       gyro_on_o,
    input wire logic [2:0] odr_o,
    input wire logic [1:0] gyro_pmode_o,
    input wire logic [1:0] gyro_fs_o,
    input wire logic [4:0] discard_left_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] prev;
    logic [1:0] calm;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    // Counts cycles since the rate or the power mode last moved, so loads are not taken for steps.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prev <= 5'h00;
            calm <= 2'h0;
        end else begin
            prev <= {odr_o, gyro_pmode_o};
            calm <= (prev != {odr_o, gyro_pmode_o}) ? 2'h0 : ((calm == 2'h3) ? calm : calm + 2'h1);
        end
    end

    gyro_state_a: assert property (gyro_on_o == (gyro_pmode_o != 2'h0) && gyro_pmode_o != 2'h3)
        else $error("gyro power state inconsistent");
    accel_run_a: assert property (accel_on_o == (odr_o != 3'h0))
        else $error("accel run flag does not follow rate");
    shared_rate_a: assert property (gyro_on_o |-> accel_on_o)
        else $error("gyro runs without accel");
    rate_code_a: assert property (odr_o != 3'h7)
        else $error("reserved rate code on output");
    fast_normal_a: assert property (gyro_on_o && odr_o >= 3'h4 |-> gyro_pmode_o == 2'h2)
        else $error("fast rate not in normal mode");
    low_rate_a: assert property (gyro_pmode_o == 2'h1 |-> odr_o inside {3'h1, 3'h2, 3'h3})
        else $error("low power at a fast rate");
    low_scale_a: assert property (gyro_pmode_o == 2'h1 |-> gyro_fs_o == 2'h3)
        else $error("low power below top full scale");
    discard_step_a: assert property (calm == 2'h3 && ce_i && sample_valid_i && discard_left_o != 5'h00 |=>
        discard_left_o == $past(discard_left_o) - 5'h01 || $changed(odr_o) || $changed(gyro_pmode_o))
        else $error("discard count did not step down");
    discard_hold_a: assert property (calm == 2'h3 && !sample_valid_i |=>
        $stable(discard_left_o) || $changed(odr_o) || $changed(gyro_pmode_o))
        else $error("discard count moved without cause");
    open_drain_a: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
endmodule // imupm_ctrl_assertions

bind imupm_ctrl imupm_ctrl_assertions u_chk (.mclk_i, .resetn_i, .ce_i, .sample_valid_i, .sda_o, .accel_on_o,
    .gyro_on_o, .odr_o, .gyro_pmode_o, .gyro_fs_o, .discard_left_o);

/* test/imupm_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the sensor mode control over its two-wire port.
// Assumes: 10 MHz clock, reset held for 12 cycles, host model as bus master.
// Notes:   Expected results queue up in order and are taken as results appear.
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin fails++; \
    $display("ERROR %s expected %h seen %h", nm, e, s); end end
module imupm_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] DEV = 7'h35;
    logic        mclk_i, resetn_i, ce_i, scl_i, sda_i, sda_low, sda_oe_o, sample_valid_i, probe;
    logic [47:0] accel_sample_i, gyro_sample_i;
    logic        accel_on_o, gyro_on_o;
    logic [2:0]  odr_o;
    logic [1:0]  gyro_pmode_o, gyro_fs_o, accel_bw_o;
    logic [4:0]  discard_left_o;
    logic [7:0]  res_val, res_n;
    string       nm_q[$];
    logic [15:0] exp_q[$];
    int          fails = 0;
    int          comparisons = 0;

    assign sda_i = !(sda_low || sda_oe_o);

    imupm_ctrl #(.DEV_ADDR(DEV)) DUT (.mclk_i, .resetn_i, .ce_i, .scl_i, .sda_i, .sda_o(), .sda_oe_o,
        .sample_valid_i, .accel_sample_i, .gyro_sample_i, .accel_on_o, .gyro_on_o, .odr_o,
        .gyro_pmode_o, .gyro_fs_o, .accel_bw_o, .discard_left_o);
    imupm_host u_host (.sda_i, .scl_o(scl_i), .sda_low_o(sda_low), .res_val_o(res_val), .res_n_o(res_n));

    // Free-running system clock.
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    function automatic logic [15:0] md(input logic a, g, input logic [2:0] r, input logic [1:0] p, f, b,
                                      input logic [4:0] d);
        return {a, g, r, p, f, b, d};
    endfunction

    task automatic note(input string nm, input logic [15:0] e);
        nm_q.push_back(nm);
        exp_q.push_back(e);
    endtask

    task automatic take(input logic [15:0] seen);
        string       nm;
        logic [15:0] e;
        nm = nm_q.pop_front();
        e = exp_q.pop_front();
        `CHK(nm, e, seen)
    endtask

    // Watches bus results and port snapshots, oldest note first.
    initial begin
        #1;
        forever begin
            @(res_n);
            take({8'h00, res_val});
        end
    end
    always @(negedge mclk_i) if (probe) take({accel_on_o, gyro_on_o, odr_o, gyro_pmode_o, gyro_fs_o,
        accel_bw_o, discard_left_o});

    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        repeat (3) note("ack", 16'h0000);
        @(posedge mclk_i) #1;
        u_host.start();
        u_host.xfer({DEV, 1'b0}, 1'b0, 1'b1);
        u_host.xfer(p, 1'b0, 1'b1);
        u_host.xfer(d, 1'b0, 1'b1);
        u_host.stop();
    endtask

    task automatic rd(input logic [7:0] p, input logic [47:0] e, input int n);
        repeat (3) note("ack", 16'h0000);
        for (int i = 0; i < n; i++) note("rdata", {8'h00, e[8*i+:8]});
        @(posedge mclk_i) #1;
        u_host.start();
        u_host.xfer({DEV, 1'b0}, 1'b0, 1'b1);
        u_host.xfer(p, 1'b0, 1'b1);
        u_host.start();
        u_host.xfer({DEV, 1'b1}, 1'b0, 1'b1);
        for (int i = 0; i < n; i++) u_host.xfer(8'hff, i < n - 1, 1'b0);
        u_host.stop();
    endtask

    task automatic snap(input logic [15:0] e);
        note("mode", e);
        @(posedge mclk_i) #1 probe = 1'b1;
        @(posedge mclk_i) #1 probe = 1'b0;
    endtask

    task automatic drain(input int n);
        repeat (n) begin
            @(posedge mclk_i) #1 sample_valid_i = 1'b1;
            @(posedge mclk_i) #1 sample_valid_i = 1'b0;
        end
    endtask

    task automatic conclude();
        if (exp_q.size() != 0) fails++;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Cuts a hang short well after the expected run of about 0.7 ms.
    initial begin
        #5_000_000;
        fails++;
        conclude();
    end

    // Main sequence.
    initial begin
        {resetn_i, sample_valid_i, probe, accel_sample_i, gyro_sample_i} = '0;
        ce_i = 1'b1;
        void'($urandom(32'h1714));
        repeat (12) @(posedge mclk_i);
        #1 resetn_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        snap(md(0, 0, 0, 0, 0, 0, 0));
        wr(8'h20, 8'hc3);
        snap(md(1, 0, 6, 0, 0, 3, 14));
        drain(14);
        snap(md(1, 0, 6, 0, 0, 3, 0));
        wr(8'h12, 8'h80);
        snap(md(1, 0, 6, 0, 0, 3, 0));
        $display("test accel only done");
        for (int r = 1; r <= 6; r++) begin
            wr(8'h10, {r[2:0], 5'h18});
            snap(md(1, 1, r[2:0], (r < 4) ? 2'h1 : 2'h2, 3, 3, (r == 4) ? 5'h04 : 5'h00));
            drain(5);
        end
        $display("test rate table done");
        wr(8'h10, 8'h20);
        snap(md(1, 1, 1, 2, 0, 3, 0));
        wr(8'h12, 8'hc0);
        wr(8'h10, 8'h78);
        snap(md(1, 1, 3, 1, 3, 3, 13));
        ce_i = 1'b0;
        drain(3);
        ce_i = 1'b1;
        snap(md(1, 1, 3, 1, 3, 3, 13));
        drain(14);
        wr(8'h10, 8'h98);
        snap(md(1, 1, 4, 2, 3, 3, 14));
        drain(15);
        $display("test low power switch done");
        wr(8'h20, 8'h40);
        snap(md(1, 0, 2, 0, 3, 0, 0));
        wr(8'h20, 8'h00);
        snap(md(0, 0, 0, 0, 3, 0, 0));
        wr(8'h20, 8'h82);
        snap(md(1, 0, 4, 0, 3, 2, 2));
        accel_sample_i = {16'($urandom()), $urandom()};
        drain(4);
        rd(8'h28, accel_sample_i, 6);
        wr(8'h10, 8'h98);
        gyro_sample_i = {16'($urandom()), $urandom()};
        drain(6);
        rd(8'h18, gyro_sample_i, 6);
        $display("test sample data done");
        rd(8'h10, 48'h98, 1);
        rd(8'h12, 48'hc0, 1);
        rd(8'h27, 48'h19, 1);
        wr(8'h30, 8'h5a);
        rd(8'h30, 48'h00, 1);
        note("nack", 16'h0001);
        @(posedge mclk_i) #1;
        u_host.start();
        u_host.xfer({DEV + 7'h01, 1'b0}, 1'b0, 1'b1);
        u_host.stop();
        $display("test register access done");
        conclude();
    end
endmodule // imupm_ctrl_tb_top

/* test/imupm_host.sv */
// Purpose: Two-wire bus master standing for the host processor.
// Assumes: Open-drain data line with pull-up; 800 ns bus clock period.
// Notes:   Each acknowledge or read byte is reported by bumping res_n_o.
module imupm_host (
    input  wire logic       sda_i,
    output logic            scl_o,
    output logic            sda_low_o,
    output logic [7:0]      res_val_o,
    output logic [7:0]      res_n_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus: clock high and data released.
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        res_val_o = 8'h00;
        res_n_o = 8'h00;
    end

    // One bus clock; data moves in the low half and is sampled mid high half.
    task automatic bitx(input logic lo, output logic s);
        sda_low_o = lo;
        #200 scl_o = 1'b1;
        #200 s = sda_i;
        #200 scl_o = 1'b0;
        #200;
    endtask

    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        sda_low_o = 1'b0;
        #200 scl_o = 1'b1;
        #400 sda_low_o = 1'b1;
        #400 scl_o = 1'b0;
        #200;
    endtask

    // Stop: data rises while the clock is high, then the bus is left free.
    task automatic stop();
        sda_low_o = 1'b1;
        #200 scl_o = 1'b1;
        #400 sda_low_o = 1'b0;
        #400;
    endtask

    // Moves one byte and its acknowledge bit; 8'hff releases the line for a read.
    task automatic xfer(input logic [7:0] tx, input logic ack_lo, input logic rep_ack);
        logic [7:0] rx;
        logic       a;
        for (int i = 7; i >= 0; i--) bitx(!tx[i], rx[i]);
        bitx(ack_lo, a);
        res_val_o = rep_ack ? {7'h00, a} : rx;
        res_n_o = res_n_o + 8'h01;
    endtask
endmodule // imupm_host
